//--- uart_tx_frame_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - start, data, optional parity, stop bits
// - data length five to eight bits
// - parity even, odd, one or zero
// - one or two stop bits
// - bit order and line polarity selectable
// - bit timing from selected base clock
// - bit period divisor plus one plus fraction/8
// - fraction field only holds zero to seven
// - receive mode with serial pin drives high
// - no transfer until channel enable set
// - buffer write sets full, generator starts next cycle
// - start bit clears full flag
// - interrupt at start from idle when mode selects it
// - full at stop end sends next, interrupts
// - empty at stop end stops, interrupts
// - clearing enable halts channel
// - writing ff to status clears the interrupt flag only
module uart_tx_frame_baud_gen
    import uart_tx_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic tx_data_pin_o,
    output logic tx_side_interrupt_o
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    logic [31:0] frame_mode_ff;
    logic [31:0] baud_div_ff;
    logic [31:0] unit_ctrl_ff;
    logic [7:0] tx_buffer_high_ff;
    logic tx_buffer_full_ff;
    logic irq_ff;
    logic ack_ff;
    tx_state_t state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bit_cnt_ff;
    logic parity_acc_ff;
    logic stop_cnt_ff;
    logic line_ff;
    logic run_ff;

    logic enable;
    logic access;
    logic wr_frame;
    logic wr_baud;
    logic wr_ctrl;
    logic wr_status;
    logic wr_buffer;
    logic [3:0] data_bits;
    logic frame_end;
    logic load_frame;

    baud_if bif ();

    base_clk_sel u_base (
        .clock_i(clock_i),
        .rst_b_i(rst_n),
        .sel_i(frame_mode_ff[FM_CLK_SEL_LSB +: 2]),
        .tick_o(bif.base_tick)
    );

    baud_gen u_baud (
        .clock_i(clock_i),
        .rst_b_i(rst_n),
        .bi(bif)
    );

    assign bif.divisor = baud_div_ff[15:0];
    assign bif.fraction = baud_div_ff[BD_FRAC_LSB +: 3];
    assign bif.run = run_ff;

    // bus: one wait cycle per access, answer on the second cycle
    assign access = (avs_read || avs_write) && !ack_ff;
    assign avs_waitrequest = access;
    assign enable = unit_ctrl_ff[UC_ENABLE];
    assign data_bits = MIN_DATA_BITS + {2'h0, frame_mode_ff[FM_LEN_LSB +: 2]};

    // the bus write takes effect on the edge waitrequest is low
    always_comb begin
        wr_frame = 1'b0;
        wr_baud = 1'b0;
        wr_ctrl = 1'b0;
        wr_status = 1'b0;
        wr_buffer = 1'b0;
        if (avs_write && ack_ff) begin
            if (avs_address == ADDR_FRAME_MODE) begin
                wr_frame = 1'b1;
            end else if (avs_address == ADDR_BAUD_DIV) begin
                wr_baud = 1'b1;
            end else if (avs_address == ADDR_UNIT_CTRL) begin
                wr_ctrl = 1'b1;
            end else if (avs_address == ADDR_STATUS) begin
                wr_status = 1'b1;
            end else if (avs_address == ADDR_TX_BUFFER) begin
                wr_buffer = avs_byteenable[0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_mode_ff <= FRAME_MODE_RST;
            baud_div_ff <= BAUD_DIV_RST;
            unit_ctrl_ff <= UNIT_CTRL_RST;
        end else begin
            if (wr_frame) begin
                frame_mode_ff <= merge(frame_mode_ff, avs_writedata, avs_byteenable) &
                                 32'h0000_03ff;
            end
            if (wr_baud) begin
                baud_div_ff <= merge(baud_div_ff, avs_writedata, avs_byteenable) &
                               32'h0007_ffff;
            end
            if (wr_ctrl) begin
                unit_ctrl_ff <= merge(unit_ctrl_ff, avs_writedata, avs_byteenable) &
                                32'h0000_000f;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (access && avs_read) begin
            if (avs_address == ADDR_FRAME_MODE) begin
                avs_readdata <= frame_mode_ff;
            end else if (avs_address == ADDR_BAUD_DIV) begin
                avs_readdata <= baud_div_ff;
            end else if (avs_address == ADDR_UNIT_CTRL) begin
                avs_readdata <= unit_ctrl_ff;
            end else if (avs_address == ADDR_STATUS) begin
                avs_readdata <= {29'h0, irq_ff, (state_ff != ST_IDLE), tx_buffer_full_ff};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // frame engine: bit_tick marks a transfer clock falling edge
    assign frame_end = bif.bit_tick && (state_ff == ST_STOP) &&
                       (stop_cnt_ff == frame_mode_ff[FM_STOP2]);
    assign load_frame = bif.bit_tick && tx_buffer_full_ff &&
                        ((state_ff == ST_IDLE) || frame_end);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer_high_ff <= 8'h00;
            tx_buffer_full_ff <= 1'b0;
        end else if (!enable) begin
            tx_buffer_full_ff <= 1'b0;
        end else if (wr_buffer) begin
            tx_buffer_high_ff <= avs_writedata[7:0];
            tx_buffer_full_ff <= 1'b1;
        end else if (load_frame) begin
            tx_buffer_full_ff <= 1'b0;
        end
    end

    // generator starts the cycle after the write
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
        end else if (!enable) begin
            run_ff <= 1'b0;
        end else if (tx_buffer_full_ff) begin
            run_ff <= 1'b1;
        end else if (state_ff == ST_IDLE) begin
            run_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 4'h0;
            parity_acc_ff <= 1'b0;
            stop_cnt_ff <= 1'b0;
            line_ff <= 1'b1;
        end else if (!enable) begin
            state_ff <= ST_IDLE;
            line_ff <= 1'b1;
        end else if (load_frame) begin
            state_ff <= ST_START;
            line_ff <= 1'b0;
            shift_ff <= tx_buffer_high_ff;
            bit_cnt_ff <= 4'h0;
            parity_acc_ff <= 1'b0;
        end else if (bif.bit_tick) begin
            case (state_ff)
                ST_IDLE: begin
                    line_ff <= 1'b1;
                end
                ST_START, ST_DATA: begin
                    if (state_ff == ST_DATA && bit_cnt_ff == data_bits) begin
                        stop_cnt_ff <= 1'b0;
                        if (frame_mode_ff[FM_PAR_EN]) begin
                            state_ff <= ST_PARITY;
                            case (frame_mode_ff[FM_PAR_LSB +: 2])
                                PAR_EVEN: line_ff <= parity_acc_ff;
                                PAR_ODD: line_ff <= ~parity_acc_ff;
                                PAR_ONE: line_ff <= 1'b1;
                                default: line_ff <= 1'b0;
                            endcase
                        end else begin
                            state_ff <= ST_STOP;
                            line_ff <= 1'b1;
                        end
                    end else begin
                        state_ff <= ST_DATA;
                        if (frame_mode_ff[FM_MSB_FIRST]) begin
                            line_ff <= shift_ff[data_bits[2:0] - 3'h1 - bit_cnt_ff[2:0]];
                            parity_acc_ff <= parity_acc_ff ^
                                shift_ff[data_bits[2:0] - 3'h1 - bit_cnt_ff[2:0]];
                        end else begin
                            line_ff <= shift_ff[bit_cnt_ff[2:0]];
                            parity_acc_ff <= parity_acc_ff ^ shift_ff[bit_cnt_ff[2:0]];
                        end
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                end
                ST_PARITY: begin
                    state_ff <= ST_STOP;
                    line_ff <= 1'b1;
                end
                default: begin
                    if (frame_end) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        stop_cnt_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // one-cycle pulse at a frame start from idle (start/end mode) or at each frame end
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_side_interrupt_o <= 1'b0;
        end else begin
            tx_side_interrupt_o <= enable &&
                ((load_frame && unit_ctrl_ff[UC_IRQ_START_END] && state_ff == ST_IDLE) ||
                 frame_end);
        end
    end

    // sticky copy readable in status; set wins over the clear
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else if (tx_side_interrupt_o) begin
            irq_ff <= 1'b1;
        end else if (wr_status && avs_writedata[7:0] == STATUS_CLEAR_ALL) begin
            irq_ff <= 1'b0;
        end
    end

    // polarity applies to every frame level, including the idle line; the receive-mode high is not inverted
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_pin_o <= 1'b1;
        end else if (unit_ctrl_ff[UC_RX_MODE] && unit_ctrl_ff[UC_PIN_SERIAL]) begin
            tx_data_pin_o <= 1'b1;
        end else begin
            tx_data_pin_o <= line_ff ^ frame_mode_ff[FM_NEG_LOGIC];
        end
    end
endmodule
`default_nettype wire

//--- uart_tx_pkg.sv
package uart_tx_pkg;

    // register byte addresses; the write-only buffer sits in the gap after frame mode
    localparam logic [3:0] ADDR_FRAME_MODE = 4'h0;
    localparam logic [3:0] ADDR_TX_BUFFER = 4'h1;
    localparam logic [3:0] ADDR_BAUD_DIV = 4'h4;
    localparam logic [3:0] ADDR_UNIT_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;

    // frame mode register fields
    localparam int FM_LEN_LSB = 0;
    localparam int FM_PAR_EN = 2;
    localparam int FM_PAR_LSB = 3;
    localparam int FM_STOP2 = 5;
    localparam int FM_MSB_FIRST = 6;
    localparam int FM_NEG_LOGIC = 7;
    localparam int FM_CLK_SEL_LSB = 8;

    // parity kinds
    localparam logic [1:0] PAR_EVEN = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_ONE = 2'h2;
    localparam logic [1:0] PAR_ZERO = 2'h3;

    // baud divisor register fields
    localparam int BD_FRAC_LSB = 16;

    // unit control register fields
    localparam int UC_ENABLE = 0;
    localparam int UC_RX_MODE = 1;
    localparam int UC_IRQ_START_END = 2;
    localparam int UC_PIN_SERIAL = 3;

    // status register fields
    localparam int ST_FULL = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_IRQ = 2;
    localparam logic [7:0] STATUS_CLEAR_ALL = 8'hff;

    // reset values
    localparam logic [31:0] FRAME_MODE_RST = 32'h0000_0003;
    localparam logic [31:0] BAUD_DIV_RST = 32'h0000_0000;
    localparam logic [31:0] UNIT_CTRL_RST = 32'h0000_0008;

    // frame layout
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_DATA = 3'b011,
        ST_PARITY = 3'b010,
        ST_STOP = 3'b110
    } tx_state_t;

endpackage

//--- baud_if.sv
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
    logic run;
    logic [15:0] divisor;
    logic [2:0] fraction;
    logic base_tick;
    logic bit_tick;

    modport gen (
        input run,
        input divisor,
        input fraction,
        input base_tick,
        output bit_tick
    );
    modport user (
        output run,
        output divisor,
        output fraction,
        output base_tick,
        input bit_tick
    );
endinterface
`default_nettype wire

//--- baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
    input wire logic clock_i,
    input wire logic rst_b_i,
    baud_if.gen bi
);
    logic [15:0] cnt_ff;
    logic [2:0] phase_ff;
    logic extra_ff;
    logic [2:0] nxt_phase;

    // lengthens "fraction" of every eight bit periods by one base cycle
    assign nxt_phase = phase_ff + 3'h1;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= 16'h0000;
            phase_ff <= 3'h0;
            extra_ff <= 1'b0;
            bi.bit_tick <= 1'b0;
        end else if (!bi.run) begin
            cnt_ff <= 16'h0000;
            phase_ff <= 3'h0;
            extra_ff <= 1'b0;
            bi.bit_tick <= 1'b0;
        end else begin
            bi.bit_tick <= 1'b0;
            if (bi.base_tick) begin
                if (cnt_ff < bi.divisor) begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end else if (!extra_ff && (phase_ff < bi.fraction)) begin
                    extra_ff <= 1'b1;
                end else begin
                    cnt_ff <= 16'h0000;
                    extra_ff <= 1'b0;
                    phase_ff <= nxt_phase;
                    bi.bit_tick <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- base_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
module base_clk_sel (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    // base clock is the system clock divided by 1, 2, 4 or 8, as an enable
    logic [2:0] div_ff;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    always_comb begin
        case (sel_i)
            2'h0: tick_o = 1'b1;
            2'h1: tick_o = (div_ff[0] == 1'b1);
            2'h2: tick_o = (div_ff[1:0] == 2'h3);
            default: tick_o = (div_ff == 3'h7);
        endcase
    end
endmodule
`default_nettype wire

//--- uart_tx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uart_tx_monitor
    import uart_tx_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic tx_data_pin_o,
    input wire logic tx_side_interrupt_o
);
    localparam logic [3:0] BUF_ADDR = ADDR_TX_BUFFER;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    logic en_ff, rx_ff, ie_ff, neg_ff, fresh_ff;
    logic [3:0] off_ff, rxc_ff;
    wire logic wr = avs_write && !avs_waitrequest;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_ff <= 1'b0;
            rx_ff <= 1'b0;
            ie_ff <= 1'b0;
        end else if (wr && avs_address == ADDR_UNIT_CTRL) begin
            en_ff <= avs_writedata[UC_ENABLE];
            rx_ff <= avs_writedata[UC_RX_MODE] && avs_writedata[UC_PIN_SERIAL];
            ie_ff <= avs_writedata[UC_IRQ_START_END];
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            neg_ff <= 1'b0;
        end else if (wr && avs_address == ADDR_FRAME_MODE) begin
            neg_ff <= avs_writedata[FM_NEG_LOGIC];
        end
    end
    // set by an enabling write, so no frame can be running at the next buffer write
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fresh_ff <= 1'b0;
        end else if (wr) begin
            fresh_ff <= avs_address == ADDR_UNIT_CTRL && avs_writedata[UC_ENABLE];
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            off_ff <= 4'h0;
        end else if (en_ff || wr) begin
            off_ff <= 4'h0;
        end else if (off_ff != 4'hf) begin
            off_ff <= off_ff + 4'h1;
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rxc_ff <= 4'h0;
        end else if (!(en_ff && rx_ff) || wr) begin
            rxc_ff <= 4'h0;
        end else if (rxc_ff != 4'hf) begin
            rxc_ff <= rxc_ff + 4'h1;
        end
    end
    sequence ask_s;
        avs_waitrequest;
    endsequence
    sequence give_s;
        !avs_waitrequest;
    endsequence
    bus_answer_a: assert property ($rose(avs_read || avs_write) |-> ask_s ##1 give_s)
        else $error("bus answer timing wrong");
    read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    halt_idle_a: assert property (off_ff > 4'h2 |-> tx_data_pin_o == !neg_ff)
        else $error("line not idle while disabled");
    irq_off_a: assert property (off_ff > 4'h2 |-> !tx_side_interrupt_o)
        else $error("interrupt while disabled");
    rx_high_a: assert property (rxc_ff > 4'h2 |-> tx_data_pin_o)
        else $error("line not high in receive mode");
    start_soon_a: assert property (wr && avs_address == BUF_ADDR && fresh_ff
        && !rx_ff && !neg_ff |-> ##[1:1000] !tx_data_pin_o)
        else $error("start bit missing");
    irq_start_a: assert property (wr && avs_address == BUF_ADDR && fresh_ff
        && !rx_ff && ie_ff |-> ##[1:1000] tx_side_interrupt_o)
        else $error("start interrupt missing");
    irq_pulse_a: assert property (tx_side_interrupt_o |=> !tx_side_interrupt_o)
        else $error("interrupt longer than a pulse");
    reset_idle_a: assert property ($rose(rst_b_i) |-> tx_data_pin_o && !tx_side_interrupt_o)
        else $error("line not idle after reset");
endmodule
bind uart_tx_frame_baud_gen uart_tx_monitor i_monitor (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_data_pin_o(tx_data_pin_o), .tx_side_interrupt_o(tx_side_interrupt_o));
`default_nettype wire

//--- remote_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module remote_rx_model (
    input wire logic clock_i,
    input wire logic line_i,
    input wire logic arm_i,
    input wire logic idle_i,
    input wire logic [3:0] nbits_i,
    input wire logic [3:0] pre_i,
    input wire logic [2:0] frac_i,
    output logic [15:0] bits_o,
    output logic done_o,
    output logic [31:0] gap_o
);
    int cyc, t0, tp, tgt;
    logic [15:0] b;
    // samples mid bit at a fixed divisor of 4; the spread of extra cycles is not known
    initial begin
        done_o = 1'b0;
        bits_o = '0;
        gap_o = '0;
        cyc = 0;
        tp = 0;
        forever begin
            @(posedge clock_i);
            cyc++;
            done_o <= 1'b0;
            if (arm_i === 1'b1 && line_i !== idle_i) begin
                t0 = cyc;
                b = '0;
                for (int k = 0; k < nbits_i; k++) begin
                    tgt = t0 + pre_i * (k * 5 + k * frac_i / 8) + pre_i * 5 / 2;
                    while (cyc < tgt) begin
                        @(posedge clock_i);
                        cyc++;
                    end
                    b[k] = line_i;
                end
                bits_o <= b;
                gap_o <= t0 - tp;
                tp = t0;
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import uart_tx_pkg::*;
;
    localparam logic [3:0] BUF_ADDR = ADDR_TX_BUFFER;
    logic clock_i, rst_b_i, avs_read, avs_write, pin, irq, done, arm, idle;
    logic [3:0] avs_address, avs_byteenable, nb, pre;
    logic [31:0] avs_writedata, rdata, gap, seed;
    logic [15:0] bits;
    logic [2:0] frac;
    logic wait_req;
    int mismatches, n_checks, irqs;
    logic [15:0] fq[$];
    int gq[$];
    uart_tx_frame_baud_gen i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(rdata), .avs_waitrequest(wait_req),
        .tx_data_pin_o(pin), .tx_side_interrupt_o(irq));
    remote_rx_model i_remote (.clock_i(clock_i), .line_i(pin), .arm_i(arm), .idle_i(idle),
        .nbits_i(nb), .pre_i(pre), .frac_i(frac), .bits_o(bits), .done_o(done), .gap_o(gap));
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (done === 1'b1) begin
            fq.push_back(bits);
            gq.push_back(int'(gap));
        end
        if (irq === 1'b1) irqs++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] frame_bits(input logic [9:0] m, input logic [7:0] d,
        output logic [3:0] n);
        int k;
        logic p;
        logic [15:0] f;
        f = '1;
        f[0] = 1'b0;
        k = 1;
        p = 1'b0;
        for (int j = 0; j < 5 + m[1:0]; j++) begin
            f[k] = m[FM_MSB_FIRST] ? d[4 + m[1:0] - j] : d[j];
            p ^= f[k];
            k++;
        end
        if (m[FM_PAR_EN]) begin
            case (m[4:3])
                PAR_EVEN: f[k] = p;
                PAR_ODD: f[k] = !p;
                PAR_ONE: f[k] = 1'b1;
                default: f[k] = 1'b0;
            endcase
            k++;
        end
        k += m[FM_STOP2] ? 2 : 1;
        n = k[3:0];
        return (m[FM_NEG_LOGIC] ? ~f : f) & ((16'h1 << k) - 16'h1);
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
            mismatches++;
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clock_i);
            n++;
        end while (wait_req !== 1'b0 && n < 40);
        r = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(n < 40, 1'b1, "bus hang");
        @(posedge clock_i);
    endtask
    task automatic drain(input logic [31:0] mask);
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            bus(1'b0, ADDR_STATUS, '0, r);
            n++;
        end while ((r & mask) !== '0 && n < 500);
        chk(r & mask, '0, "status stuck");
    endtask
    task automatic take(input logic [15:0] e, input int lo, input int hi);
        int n;
        n = 0;
        while (fq.size() == 0 && n < 3000) begin
            @(posedge clock_i);
            n++;
        end
        chk(fq.size() > 0, 1'b1, "no frame");
        if (fq.size() > 0) begin
            chk(fq.pop_front(), e, "frame bits");
            n = gq.pop_front();
            chk(n >= lo && n <= hi, 1'b1, "frame spacing");
        end
    endtask
    initial begin
        logic [31:0] r;
        logic [9:0] m;
        logic [7:0] d0, d1;
        logic [15:0] e0, e1;
        logic [3:0] n;
        int p;
        {rst_b_i, avs_read, avs_write, arm, idle, avs_address, avs_writedata} = '0;
        {nb, pre, frac, mismatches, n_checks, irqs} = '0;
        avs_byteenable = 4'hf;
        seed = 32'h9c75;
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        bus(1'b0, ADDR_FRAME_MODE, '0, r);
        chk(r, FRAME_MODE_RST, "mode reset");
        bus(1'b0, ADDR_UNIT_CTRL, '0, r);
        chk(r, UNIT_CTRL_RST, "control reset");
        bus(1'b0, 4'h3, '0, r);
        chk(r, '0, "unmapped read");
        bus(1'b1, ADDR_STATUS, {24'h0, STATUS_CLEAR_ALL}, r);
        for (int i = 0; i < 8; i++) begin
            m = {~i[1:0], i[2], i[1] ^ i[2], i[0], i[1:0] + 2'h1, i != 6, i[1:0]};
            p = 8 >> i[1:0];
            arm <= 1'b0;
            bus(1'b1, ADDR_UNIT_CTRL, 32'h8, r);
            bus(1'b1, ADDR_FRAME_MODE, {22'h0, m}, r);
            bus(1'b0, ADDR_FRAME_MODE, '0, r);
            chk(r, {22'h0, m}, "mode readback");
            bus(1'b1, ADDR_BAUD_DIV, {12'h0, 1'b1, 3'(i), 16'h0004}, r);
            bus(1'b0, ADDR_BAUD_DIV, '0, r);
            chk(r, {13'h0, 3'(i), 16'h0004}, "baud readback");
            bus(1'b1, ADDR_UNIT_CTRL, {29'h1, i[0], 2'h1}, r);
            seed = lfsr(lfsr(seed));
            {d0, d1} = seed[15:0];
            e0 = frame_bits(m, d0, n);
            e1 = frame_bits(m, d1, n);
            {idle, nb, pre, frac} <= {~m[FM_NEG_LOGIC], n, 4'(p), 3'(i)};
            repeat (4) @(posedge clock_i);
            arm <= 1'b1;
            irqs = 0;
            bus(1'b1, BUF_ADDR, {24'h0, d0}, r);
            if (p == 8) begin
                bus(1'b0, ADDR_STATUS, '0, r);
                chk(r[ST_FULL], 1'b1, "full after write");
            end
            drain(32'h1);
            bus(1'b1, BUF_ADDR, {24'h0, d1}, r);
            take(e0, 0, 32'h7fffffff);
            take(e1, p * (n * 5 + n * i / 8), p * (n * 5 + (n * i + 7) / 8));
            drain(32'h3);
            chk(irqs >= (i[0] ? 3 : 2) && irqs <= (i[0] ? 4 : 2), 1'b1, "irq count");
        end
        bus(1'b0, ADDR_STATUS, '0, r);
        chk(r[ST_IRQ], 1'b1, "sticky irq");
        bus(1'b1, ADDR_STATUS, {24'h0, STATUS_CLEAR_ALL}, r);
        bus(1'b0, ADDR_STATUS, '0, r);
        chk(r[ST_IRQ], 1'b0, "irq not cleared");
        arm <= 1'b0;
        bus(1'b1, BUF_ADDR, {24'h0, seed[23:16]}, r);
        drain(32'h1);
        bus(1'b1, ADDR_UNIT_CTRL, 32'h8, r);
        bus(1'b0, ADDR_STATUS, '0, r);
        chk(r[1:0], 2'h0, "abort left busy");
        bus(1'b1, ADDR_FRAME_MODE, FRAME_MODE_RST, r);
        bus(1'b1, ADDR_UNIT_CTRL, 32'hb, r);
        bus(1'b1, BUF_ADDR, 32'h0, r);
        repeat (200) @(posedge clock_i);
        chk(pin, 1'b1, "receive mode line");
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clock_i);
        mismatches++;
        $display("[FAIL] %0t run timed out", $time);
        complete_run();
    end
endmodule
`default_nettype wire
